// *** hdl/cmsp_pkg.sv ***
package cmsp_pkg;

    // mode encodings {c,b,a}
    typedef enum logic [2:0]
    {
        CMSP_SPECIAL_SINGLE = 3'h0,
        CMSP_EMUL_NARROW = 3'h1,
        CMSP_SPECIAL_TEST = 3'h2,
        CMSP_EMUL_WIDE = 3'h3,
        CMSP_NORMAL_SINGLE = 3'h4,
        CMSP_NORMAL_NARROW = 3'h5,
        CMSP_PERIPHERAL = 3'h6,
        CMSP_NORMAL_WIDE = 3'h7
    } cmsp_mode_e;

    typedef enum logic [1:0]
    {
        CMSP_PWR_RUN = 2'h0,
        CMSP_PWR_WAIT = 2'h1,
        CMSP_PWR_PSTOP = 2'h2,
        CMSP_PWR_STOP = 2'h3
    } cmsp_pwr_e;

    typedef enum logic [1:0]
    {
        CMSP_VER_IDLE = 2'h0,
        CMSP_VER_RUN = 2'h1,
        CMSP_VER_PASS = 2'h2,
        CMSP_VER_FAIL = 2'h3
    } cmsp_ver_e;

    // register byte offsets
    localparam logic [7:0] CMSP_OFS_MODE = 8'h00;
    localparam logic [7:0] CMSP_OFS_MISC = 8'h04;
    localparam logic [7:0] CMSP_OFS_STATUS = 8'h08;
    localparam logic [7:0] CMSP_OFS_POWER = 8'h0C;
    localparam logic [7:0] CMSP_OFS_DEBUG = 8'h10;

    // field positions
    localparam int CMSP_MISC_VIS = 0;
    localparam int CMSP_ST_SECURE = 0;
    localparam int CMSP_ST_BDG_ACT = 1;
    localparam int CMSP_ST_BDG_BLK = 2;
    localparam int CMSP_ST_OSC_SEL = 3;
    localparam int CMSP_ST_VER_LO = 4;
    localparam int CMSP_ST_UNLOCK = 6;
    localparam int CMSP_ST_MODE_LO = 8;
    localparam int CMSP_PW_STOP = 0;
    localparam int CMSP_PW_WAIT = 1;
    localparam int CMSP_PW_PSEUDO = 2;
    localparam int CMSP_PW_KEEP_PI = 3;
    localparam int CMSP_PW_KEEP_WD = 4;
    localparam int CMSP_PW_STATE_LO = 8;

    localparam logic [1:0] CMSP_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] CMSP_HSIZE_WORD = 3'h2;

    // erase-check walk over the flash words
    localparam int CMSP_FLASH_AW = 8;
    localparam logic [CMSP_FLASH_AW-1:0] CMSP_FLASH_LAST = 8'hFF;
    localparam logic [15:0] CMSP_ERASED_WORD = 16'hFFFF;

    typedef struct packed
    {
        logic [7:0] addr;
        logic write;
        logic sel;
    } cmsp_req_s;

    typedef struct packed
    {
        logic map_flash;
        logic osc_colpitts;
        logic bdg_active;
        logic bdg_blocked;
        logic unlock_ok;
    } cmsp_cfg_s;

    typedef struct packed
    {
        logic clk_halt;
        logic osc_run;
        logic pi_run;
        logic wd_run;
        logic periph_run;
        logic cpu_hold;
    } cmsp_pwr_s;

endpackage

// *** hdl/cmsp_top.sv ***
// Function
// (R01) mode pins captured into mode bits at reset release; bits show mode
// (R02) flash-visible bit derived at reset release from rom control pin via mode table
// (R03) flash mapped only while flash-visible bit is 1
// (R04) 000: special single-chip, debug active at once, visible forced 1
// (R05) 001: emulation narrow, visible is inverse of rom control pin
// (R06) 010: special test wide, visible forced 0
// (R07) 011: emulation wide, visible is inverse of rom control pin
// (R08) 100: normal single-chip, visible forced 1
// (R09) 101: normal narrow, visible equals rom control pin
// (R10) board must never strap 110 peripheral mode
// (R11) 111: normal wide, visible equals rom control pin
// (R12) other modes: debug permitted, inactive until host serial command
// (R13) oscillator select pin 1 picks colpitts, 0 pierce or external
// (R14) software may write mode bits only along restricted transitions
// (R15) secured normal single-chip: unchanged except debug blocked; code also ignores MISC flash-visible writes while secured
// (R16) secured expanded reset: flash disabled, debug blocked, external run allowed
// (R17) secured state taken from non-volatile bits, persists over resets
// (R18) reset before security bits reprogrammed secures device again
// (R19) special single-chip reset runs erase check; unlock only after it passes
// (R20) full stop halts all clocks and oscillator; wake by reset or interrupt
// (R21) pseudo stop keeps oscillator, optional periodic and watchdog units
// (R22) wait stops cpu and holds buses; peripherals active
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module cmsp_top
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic mode_select_c,
    input wire logic mode_select_b,
    input wire logic mode_select_a,
    input wire logic rom_control_pin,
    input wire logic oscillator_select_pin,
    input wire logic sec_bits_secure,
    input wire logic bdg_cmd_activate,
    input wire logic stop_instr,
    input wire logic wait_instruction,
    input wire logic ext_irq,
    output logic [cmsp_pkg::CMSP_FLASH_AW-1:0] flash_rd_addr,
    input wire logic [15:0] flash_rd_data,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output cmsp_pkg::cmsp_cfg_s cfg_out,
    output cmsp_pkg::cmsp_pwr_s pwr_out
);
    import cmsp_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // three-stage sync of the strap pins
    logic [4:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
    logic boot_ff;
    logic [2:0] mode_ff;
    logic vis_ff;
    logic osc_ff;
    logic secure_ff;
    logic bdg_act_ff;
    logic [CMSP_FLASH_AW-1:0] ver_addr_ff;
    cmsp_ver_e ver_ff;
    cmsp_pwr_e pwr_ff;
    logic keep_pi_ff, keep_wd_ff, pseudo_ff;
    cmsp_req_s req_ff;
    logic [31:0] rdata_ff;

    logic [2:0] pin_mode;
    logic pin_rom;
    logic nxt_vis;
    logic expanded;

    assign pin_mode = pin_s3_ff[4:2];
    assign pin_rom = pin_s3_ff[1];

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_s1_ff <= 5'h00;
            pin_s2_ff <= 5'h00;
            pin_s3_ff <= 5'h00;
        end
        else if (clk_en)
        begin
            pin_s1_ff <= {mode_select_c, mode_select_b, mode_select_a, rom_control_pin, oscillator_select_pin};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    // mode table for flash visibility
    always_comb
    begin
        case (cmsp_mode_e'(pin_mode))
            CMSP_SPECIAL_SINGLE: nxt_vis = 1'b1; // R04
            CMSP_EMUL_NARROW: nxt_vis = ~pin_rom; // R05
            CMSP_SPECIAL_TEST: nxt_vis = 1'b0; // R06
            CMSP_EMUL_WIDE: nxt_vis = ~pin_rom; // R07
            CMSP_NORMAL_SINGLE: nxt_vis = 1'b1; // R08
            CMSP_NORMAL_NARROW: nxt_vis = pin_rom; // R09
            CMSP_PERIPHERAL: nxt_vis = 1'b1; // R10
            CMSP_NORMAL_WIDE: nxt_vis = pin_rom; // R11
            default: nxt_vis = 1'b1;
        endcase
    end

    assign expanded = (mode_ff != CMSP_SPECIAL_SINGLE) && (mode_ff != CMSP_NORMAL_SINGLE);

    // bus write decode
    logic wr_go;
    logic [2:0] nxt_mode;
    logic mode_ok;
    assign wr_go = req_ff.sel && req_ff.write;
    assign nxt_mode = hwdata[2:0];

    // permitted switches: special single-chip to any but peripheral,
    // normal single-chip to a normal expanded mode, narrow to wide
    always_comb
    begin
        mode_ok = 1'b0;
        if (nxt_mode == mode_ff)
            mode_ok = 1'b1;
        else if (nxt_mode == CMSP_PERIPHERAL)
            mode_ok = 1'b0;
        else if (mode_ff == CMSP_SPECIAL_SINGLE)
            mode_ok = 1'b1;
        else if (mode_ff == CMSP_NORMAL_SINGLE)
            mode_ok = (nxt_mode == CMSP_NORMAL_NARROW) || (nxt_mode == CMSP_NORMAL_WIDE);
        else if (mode_ff == CMSP_NORMAL_NARROW)
            mode_ok = (nxt_mode == CMSP_NORMAL_WIDE);
        else if (mode_ff == CMSP_EMUL_NARROW)
            mode_ok = (nxt_mode == CMSP_EMUL_WIDE);
    end

    // boot capture one cycle after sync has filled
    logic [1:0] boot_cnt_ff;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            boot_cnt_ff <= 2'h0;
            boot_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (boot_cnt_ff != 2'h3)
                boot_cnt_ff <= boot_cnt_ff + 2'h1;
            boot_ff <= (boot_cnt_ff == 2'h2);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_ff <= 3'h0;
            vis_ff <= 1'b0;
            osc_ff <= 1'b0;
            secure_ff <= 1'b1;
        end
        else if (clk_en)
        begin
            if (boot_ff)
            begin
                mode_ff <= pin_mode; // R01
                vis_ff <= nxt_vis; // R02
                osc_ff <= pin_s3_ff[0]; // R13
                secure_ff <= sec_bits_secure; // R17 R18
            end
            else if (wr_go && req_ff.addr == CMSP_OFS_MODE && mode_ok)
                mode_ff <= nxt_mode; // R14
            else if (wr_go && req_ff.addr == CMSP_OFS_MISC && !secure_ff)
                vis_ff <= hwdata[CMSP_MISC_VIS];
        end
    end

    // erase check of the flash after reset into special single-chip
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ver_ff <= CMSP_VER_IDLE;
            ver_addr_ff <= '0;
        end
        else if (clk_en)
        begin
            case (ver_ff)
                CMSP_VER_IDLE:
                begin
                    if (boot_ff && pin_mode == CMSP_SPECIAL_SINGLE)
                        ver_ff <= CMSP_VER_RUN; // R19
                    ver_addr_ff <= '0;
                end
                CMSP_VER_RUN:
                begin
                    if (flash_rd_data != CMSP_ERASED_WORD)
                        ver_ff <= CMSP_VER_FAIL; // R19
                    else if (ver_addr_ff == CMSP_FLASH_LAST)
                        ver_ff <= CMSP_VER_PASS;
                    else
                        ver_addr_ff <= ver_addr_ff + 8'h01;
                end
                CMSP_VER_PASS: ver_ff <= CMSP_VER_PASS;
                CMSP_VER_FAIL: ver_ff <= CMSP_VER_FAIL;
                default: ver_ff <= CMSP_VER_IDLE;
            endcase
        end
    end
    assign flash_rd_addr = ver_addr_ff;

    // debug activation
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            bdg_act_ff <= 1'b0;
        else if (clk_en)
        begin
            if (boot_ff)
                bdg_act_ff <= (pin_mode == CMSP_SPECIAL_SINGLE); // R04 R12
            else if (bdg_cmd_activate)
                bdg_act_ff <= 1'b1; // R12
        end
    end

    // power modes
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pwr_ff <= CMSP_PWR_RUN;
            keep_pi_ff <= 1'b0;
            keep_wd_ff <= 1'b0;
            pseudo_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_go && req_ff.addr == CMSP_OFS_POWER)
            begin
                pseudo_ff <= hwdata[CMSP_PW_PSEUDO];
                keep_pi_ff <= hwdata[CMSP_PW_KEEP_PI];
                keep_wd_ff <= hwdata[CMSP_PW_KEEP_WD];
            end
            case (pwr_ff)
                CMSP_PWR_RUN:
                begin
                    if (stop_instr)
                        pwr_ff <= pseudo_ff ? CMSP_PWR_PSTOP : CMSP_PWR_STOP; // R20 R21
                    else if (wait_instruction)
                        pwr_ff <= CMSP_PWR_WAIT; // R22
                end
                CMSP_PWR_WAIT: if (ext_irq) pwr_ff <= CMSP_PWR_RUN;
                CMSP_PWR_PSTOP: if (ext_irq) pwr_ff <= CMSP_PWR_RUN;
                CMSP_PWR_STOP: if (ext_irq) pwr_ff <= CMSP_PWR_RUN; // R20
                default: pwr_ff <= CMSP_PWR_RUN;
            endcase
        end
    end

    // configuration outputs
    always_comb
    begin
        cfg_out.map_flash = vis_ff && !(secure_ff && expanded); // R03 R16
        cfg_out.osc_colpitts = osc_ff; // R13
        cfg_out.bdg_blocked = secure_ff; // R15 R16
        cfg_out.bdg_active = bdg_act_ff && !secure_ff; // R15
        cfg_out.unlock_ok = (ver_ff == CMSP_VER_PASS); // R19
        pwr_out.clk_halt = (pwr_ff == CMSP_PWR_STOP); // R20
        pwr_out.osc_run = (pwr_ff != CMSP_PWR_STOP); // R20 R21
        pwr_out.pi_run = (pwr_ff == CMSP_PWR_RUN) || (pwr_ff == CMSP_PWR_WAIT) ||
                         (pwr_ff == CMSP_PWR_PSTOP && keep_pi_ff); // R21
        pwr_out.wd_run = (pwr_ff == CMSP_PWR_RUN) || (pwr_ff == CMSP_PWR_WAIT) ||
                         (pwr_ff == CMSP_PWR_PSTOP && keep_wd_ff); // R21
        pwr_out.periph_run = (pwr_ff == CMSP_PWR_RUN) || (pwr_ff == CMSP_PWR_WAIT); // R22
        pwr_out.cpu_hold = (pwr_ff != CMSP_PWR_RUN); // R22
    end

    // ahb-lite slave: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            req_ff <= '0;
        else if (clk_en && hready)
        begin
            req_ff.sel <= hsel && (htrans == CMSP_HTRANS_NONSEQ) && (hsize == CMSP_HSIZE_WORD);
            req_ff.write <= hwrite;
            req_ff.addr <= haddr[7:0];
        end
    end

    // read data registered from the address phase
    logic [31:0] nxt_rdata;
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        case (haddr[7:0])
            CMSP_OFS_MODE: nxt_rdata[2:0] = mode_ff;
            CMSP_OFS_MISC: nxt_rdata[CMSP_MISC_VIS] = vis_ff;
            CMSP_OFS_STATUS:
            begin
                nxt_rdata[CMSP_ST_SECURE] = secure_ff;
                nxt_rdata[CMSP_ST_BDG_ACT] = cfg_out.bdg_active;
                nxt_rdata[CMSP_ST_BDG_BLK] = secure_ff;
                nxt_rdata[CMSP_ST_OSC_SEL] = osc_ff;
                nxt_rdata[CMSP_ST_VER_LO +: 2] = ver_ff;
                nxt_rdata[CMSP_ST_UNLOCK] = cfg_out.unlock_ok;
                nxt_rdata[CMSP_ST_MODE_LO +: 3] = mode_ff;
            end
            CMSP_OFS_POWER:
            begin
                nxt_rdata[CMSP_PW_PSEUDO] = pseudo_ff;
                nxt_rdata[CMSP_PW_KEEP_PI] = keep_pi_ff;
                nxt_rdata[CMSP_PW_KEEP_WD] = keep_wd_ff;
                nxt_rdata[CMSP_PW_STATE_LO +: 2] = pwr_ff;
            end
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            rdata_ff <= 32'h0000_0000;
        else if (clk_en && hready && hsel && !hwrite)
            rdata_ff <= nxt_rdata;
    end
    assign hrdata = rdata_ff;

    property p_vis_map;
        cfg_out.map_flash |-> vis_ff;
    endproperty
    a_vis_map: assert property (p_vis_map) else $error("flash mapped while not visible"); // R03
    property p_boot_mode;
        (boot_ff && clk_en) |=> (mode_ff == $past(pin_mode));
    endproperty
    a_boot_mode: assert property (p_boot_mode) else $error("mode not captured"); // R01
    property p_boot_vis;
        (boot_ff && clk_en && pin_mode == CMSP_SPECIAL_TEST) |=> !vis_ff;
    endproperty
    a_boot_vis: assert property (p_boot_vis) else $error("special test left flash visible"); // R06
    property p_ssc_debug;
        (boot_ff && clk_en && pin_mode == CMSP_SPECIAL_SINGLE && !sec_bits_secure) |=> cfg_out.bdg_active;
    endproperty
    a_ssc_debug: assert property (p_ssc_debug) else $error("debug not active in special single"); // R04
    property p_secure_block;
        secure_ff |-> (cfg_out.bdg_blocked && !cfg_out.bdg_active);
    endproperty
    a_secure_block: assert property (p_secure_block) else $error("debug open while secured"); // R15
    property p_secure_exp;
        (secure_ff && expanded) |-> !cfg_out.map_flash;
    endproperty
    a_secure_exp: assert property (p_secure_exp) else $error("flash mapped secured expanded"); // R16
    property p_stop;
        (pwr_ff == CMSP_PWR_STOP) |-> (pwr_out.clk_halt && !pwr_out.osc_run && !pwr_out.periph_run);
    endproperty
    a_stop: assert property (p_stop) else $error("clocks running in stop"); // R20
    property p_pstop;
        (pwr_ff == CMSP_PWR_PSTOP) |-> (pwr_out.osc_run && !pwr_out.periph_run && pwr_out.wd_run == keep_wd_ff);
    endproperty
    a_pstop: assert property (p_pstop) else $error("pseudo stop gating wrong"); // R21
    property p_wait;
        (clk_en && pwr_ff == CMSP_PWR_RUN && !stop_instr && wait_instruction) |=> (pwr_out.cpu_hold && pwr_out.periph_run);
    endproperty
    a_wait: assert property (p_wait) else $error("wait entry wrong"); // R22
    property p_unlock;
        $rose(cfg_out.unlock_ok) |-> ($past(ver_ff) == CMSP_VER_RUN) && ($past(flash_rd_addr) == CMSP_FLASH_LAST);
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock without erase check"); // R19
    property p_no_periph_write;
        (clk_en && !boot_ff) |=> (mode_ff != CMSP_PERIPHERAL || $past(mode_ff) == CMSP_PERIPHERAL);
    endproperty
    a_no_periph_write: assert property (p_no_periph_write) else $error("switched into peripheral mode"); // R14

    c_stop: cover property (pwr_ff == CMSP_PWR_STOP);
    c_pstop: cover property (pwr_ff == CMSP_PWR_PSTOP);
    c_pass: cover property (ver_ff == CMSP_VER_PASS);
    c_switch: cover property (wr_go && mode_ok && nxt_mode != mode_ff);

endmodule // cmsp_top

`default_nettype wire

// *** tb/cmsp_board.sv ***
`timescale 1ns/1ps
`default_nettype none

module cmsp_board
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [2:0] st_mode,
    input wire logic st_rom,
    input wire logic st_osc,
    input wire logic st_sec,
    input wire logic bad_word,
    input wire logic dbg_req,
    input wire logic [7:0] flash_rd_addr,
    output logic mode_select_c,
    output logic mode_select_b,
    output logic mode_select_a,
    output logic rom_control_pin,
    output logic oscillator_select_pin,
    output logic sec_bits_secure,
    output logic bdg_cmd_activate,
    output logic [15:0] flash_rd_data
);
    logic [2:0] hold_ff;
    logic [4:0] pins;

    // straps stay put past the capture edge, then the pins return to port use
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            hold_ff <= 3'h0;
        else if (hold_ff != 3'h6)
            hold_ff <= hold_ff + 3'h1;
    end

    assign pins = {(st_mode == 3'h6) ? 3'h7 : st_mode, st_rom, st_osc};
    assign {mode_select_c, mode_select_b, mode_select_a, rom_control_pin, oscillator_select_pin} =
        (hold_ff == 3'h6) ? ~pins : pins;
    assign sec_bits_secure = st_sec;

    // debug host: serial command decoded into a one-cycle activate
    always_ff @(posedge clk_sys)
        bdg_cmd_activate <= dbg_req;

    // one word left unerased when asked
    assign flash_rd_data = (bad_word && flash_rd_addr == 8'hA5) ? 16'h7FFF : 16'hFFFF;
endmodule // cmsp_board

`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
    import cmsp_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [2:0] st_mode = 3'h4;
    logic st_rom = 1'b0, st_osc = 1'b0, st_sec = 1'b0, bad_word = 1'b0;
    logic dbg_req = 1'b0, stop_instr = 1'b0, wait_instruction = 1'b0, ext_irq = 1'b0;
    logic clk_en = 1'b1;
    logic mc, mb, ma, romp, oscp, secb, bdg, hreadyout, hresp;
    logic [7:0] fa;
    logic [15:0] fd;
    logic [31:0] hrdata, rd;
    cmsp_cfg_s cfg_out;
    cmsp_pwr_s pwr_out;
    int n_errors = 0;
    int num_checks = 0;

    always #5 clk_sys = ~clk_sys;

    cmsp_board board
    (
        .clk_sys(clk_sys), .nrst(nrst), .st_mode(st_mode), .st_rom(st_rom), .st_osc(st_osc),
        .st_sec(st_sec), .bad_word(bad_word), .dbg_req(dbg_req), .flash_rd_addr(fa),
        .mode_select_c(mc), .mode_select_b(mb), .mode_select_a(ma), .rom_control_pin(romp),
        .oscillator_select_pin(oscp), .sec_bits_secure(secb), .bdg_cmd_activate(bdg), .flash_rd_data(fd)
    );

    cmsp_top dut
    (
        .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .mode_select_c(mc), .mode_select_b(mb),
        .mode_select_a(ma), .rom_control_pin(romp), .oscillator_select_pin(oscp), .sec_bits_secure(secb),
        .bdg_cmd_activate(bdg), .stop_instr(stop_instr), .wait_instruction(wait_instruction),
        .ext_irq(ext_irq), .flash_rd_addr(fa), .flash_rd_data(fd), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cfg_out(cfg_out), .pwr_out(pwr_out)
    );

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy();
        int k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            n_errors++;
            end_sim();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= CMSP_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= CMSP_HSIZE_WORD;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    task automatic boot(input logic [2:0] m, input logic rom, osc, sec, bad);
        @(posedge clk_sys);
        nrst <= 1'b0;
        st_mode <= m;
        st_rom <= rom;
        st_osc <= osc;
        st_sec <= sec;
        bad_word <= bad;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask

    // 0 debug command, 1 stop, 2 wait, 3 external interrupt
    task automatic pulse(input int w);
        @(posedge clk_sys);
        {dbg_req, stop_instr, wait_instruction, ext_irq} <= 4'h8 >> w;
        @(posedge clk_sys);
        {dbg_req, stop_instr, wait_instruction, ext_irq} <= 4'h0;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic mode_wr(input logic [2:0] w, input logic [2:0] e);
        bus(1'b1, CMSP_OFS_MODE, {29'h0, w});
        bus(1'b0, CMSP_OFS_MODE, 32'h0);
        check(rd, {29'h0, e});
    endtask

    task automatic poll_ver();
        int k = 0;
        do
        begin
            bus(1'b0, CMSP_OFS_STATUS, 32'h0);
            k++;
        end
        while (rd[5:4] < 2'h2 && k < 200);
        if (k >= 200)
        begin
            n_errors++;
            end_sim();
        end
    endtask

    task automatic t_modes();
        logic [2:0] m;
        logic r, v;
        for (int i = 0; i < 16; i++)
        begin
            m = i[3:1];
            r = i[0];
            if (m != 3'h6)
            begin
                boot(m, r, r, 1'b0, 1'b0);
                case (m)
                    3'h0, 3'h4: v = 1'b1;
                    3'h1, 3'h3: v = ~r;
                    3'h2: v = 1'b0;
                    default: v = r;
                endcase
                bus(1'b0, CMSP_OFS_STATUS, 32'h0);
                check({21'h0, rd[10:8], 4'h0, rd[3], 1'b0, rd[1:0]}, {21'h0, m, 4'h0, r, 1'b0, m == 3'h0, 1'b0});
                bus(1'b0, CMSP_OFS_MISC, 32'h0);
                check(rd, {31'h0, v});
                check({30'h0, cfg_out.map_flash, cfg_out.osc_colpitts}, {30'h0, v, r});
            end
        end
        boot(3'h4, 1'b0, 1'b0, 1'b0, 1'b0);
        pulse(0);
        check({31'h0, cfg_out.bdg_active}, 32'h1);
    endtask

    task automatic t_secure();
        boot(3'h4, 1'b0, 1'b0, 1'b1, 1'b0);
        bus(1'b0, CMSP_OFS_STATUS, 32'h0);
        check({26'h0, rd[10:8], rd[2:0]}, {26'h0, 3'h4, 3'h5});
        pulse(0);
        check({29'h0, cfg_out.map_flash, cfg_out.bdg_active, cfg_out.bdg_blocked}, 32'h5);
        bus(1'b1, CMSP_OFS_MISC, 32'h0);
        bus(1'b0, CMSP_OFS_MISC, 32'h0);
        check(rd, 32'h1);
        for (int i = 0; i < 2; i++)
        begin
            boot(3'h7, 1'b1, 1'b0, 1'b1, 1'b0);
            bus(1'b0, CMSP_OFS_STATUS, 32'h0);
            check({26'h0, rd[10:8], rd[2:0]}, {26'h0, 3'h7, 3'h5});
            check({31'h0, cfg_out.map_flash}, 32'h0);
        end
    endtask

    task automatic t_erase();
        boot(3'h0, 1'b0, 1'b0, 1'b1, 1'b0);
        poll_ver();
        check({29'h0, rd[6:4]}, 32'h6);
        boot(3'h4, 1'b0, 1'b0, 1'b1, 1'b0);
        bus(1'b0, CMSP_OFS_STATUS, 32'h0);
        check({30'h0, rd[6], rd[0]}, 32'h1);
        boot(3'h0, 1'b0, 1'b0, 1'b1, 1'b1);
        poll_ver();
        check({29'h0, rd[6:4]}, 32'h3);
    endtask

    task automatic t_modesw();
        boot(3'h4, 1'b0, 1'b0, 1'b0, 1'b0);
        mode_wr(3'h5, 3'h5);
        mode_wr(3'h4, 3'h5);
        mode_wr(3'h7, 3'h7);
        mode_wr(3'h6, 3'h7);
        bus(1'b1, CMSP_OFS_MISC, 32'h0);
        @(posedge clk_sys);
        check({31'h0, cfg_out.map_flash}, 32'h0);
        bus(1'b1, 8'h20, 32'hFFFFFFFF);
        bus(1'b0, 8'h20, 32'h0);
        check(rd, 32'h0);
        boot(3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        mode_wr(3'h6, 3'h0);
        mode_wr(3'h2, 3'h2);
        boot(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
        mode_wr(3'h3, 3'h3);
        mode_wr(3'h5, 3'h3);
    endtask

    task automatic pwr_chk(input int w, input logic [1:0] st, input logic [5:0] exp, input logic [5:0] msk);
        pulse(w);
        bus(1'b0, CMSP_OFS_POWER, 32'h0);
        check({24'h0, rd[9:8], pwr_out & msk}, {24'h0, st, exp});
    endtask

    task automatic t_power();
        boot(3'h4, 1'b0, 1'b0, 1'b0, 1'b0);
        clk_en <= 1'b0;
        pulse(1);
        check({26'h0, pwr_out}, 32'h1E);
        clk_en <= 1'b1;
        pwr_chk(1, 2'h3, 6'h20, 6'h3E);
        pwr_chk(3, 2'h0, 6'h1E, 6'h3F);
        bus(1'b1, CMSP_OFS_POWER, 32'h0C);
        pwr_chk(1, 2'h2, 6'h18, 6'h3E);
        pwr_chk(3, 2'h0, 6'h1E, 6'h3F);
        bus(1'b1, CMSP_OFS_POWER, 32'h14);
        pwr_chk(1, 2'h2, 6'h14, 6'h3E);
        pwr_chk(3, 2'h0, 6'h1E, 6'h3F);
        pwr_chk(2, 2'h1, 6'h1F, 6'h3F);
        pwr_chk(3, 2'h0, 6'h1E, 6'h3F);
    endtask

    initial
    begin
        t_modes();
        t_secure();
        t_erase();
        t_modesw();
        t_power();
        end_sim();
    end
endmodule // tb

`default_nettype wire
